// ### core/ict_pkg.sv
// Purpose: shared constants for the instruction cycle timing block
// Assumes: 16-bit address space, 32-bit APB data
// Notes:   offsets are byte addresses on the APB
package ict_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0]  OFS_WAIT_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_BUS_CTRL   = 8'h04;
	localparam logic [7:0]  OFS_LAST_TOTAL = 8'h08;
	localparam logic [7:0]  OFS_CYC_ACCUM  = 8'h0C;
	localparam logic [7:0]  OFS_PORT_OUT   = 8'h10;
	localparam logic [15:0] WAIT_CTRL_RST  = 16'h0000;
	localparam logic [31:0] BUS_CTRL_RST   = 32'h0000_0000;
	// wait control: one nibble per 16 KB region
	localparam int          REGION_NIB     = 4;
	localparam int          WAIT_LSB       = 0;
	localparam int          HS_BIT         = 3;
	// bus control fields
	localparam int          BUS8_BIT       = 0;
	localparam int          PORT_DIR_LSB   = 8;
	// ------------------------------------------------------------
	// address windows
	// ------------------------------------------------------------
	localparam logic [15:0] ROM_LAST       = 16'hBFFF;
	localparam logic [15:0] PRAM_FIRST     = 16'hF700;
	localparam logic [15:0] PRAM_LAST      = 16'hFDFF;
	localparam logic [15:0] SFR_LO_FIRST   = 16'hFF00;
	localparam logic [15:0] SFR_LO_LAST    = 16'hFF1F;
	// ------------------------------------------------------------
	// timing counts in clocks
	// ------------------------------------------------------------
	localparam logic [3:0]  FETCH_BASE     = 4'h3;
	localparam logic [3:0]  SADDR_PENALTY  = 4'h4;
	localparam logic [3:0]  FLUSH_BASE     = 4'h7;
	localparam logic [1:0]  FLUSH_HS_SPAN  = 2'h1;
	localparam logic [1:0]  FLUSH_NF_SPAN  = 2'h3;
	// ------------------------------------------------------------
	// fixed vectors
	// ------------------------------------------------------------
	localparam logic [15:0] VEC_RESET      = 16'h0000;
	localparam logic [15:0] VEC_BREAK      = 16'h003E;
	localparam logic [15:0] VEC_TRAP       = 16'h003C;
	// ------------------------------------------------------------
	// special register classes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ICT_SFR_PLAIN,
		ICT_SFR_TIMER_ZERO,
		ICT_SFR_TIMER_ONE_TWO,
		ICT_SFR_TIMER_THREE,
		ICT_SFR_UPDOWN,
		ICT_SFR_COMPARE,
		ICT_SFR_UPDOWN_COMPARE,
		ICT_SFR_TIMER_MODE,
		ICT_SFR_UPDOWN_MODE,
		ICT_SFR_IRQ_CTRL,
		ICT_SFR_EXTERNAL,
		ICT_SFR_WAIT_CTRL
	} ict_sfr_class_e;
endpackage

// ### core/ict_sfr_penalty.sv
// Purpose: per-access clock increase of a special register operand
// Assumes: peripheral state is given as an offset into the allowed range
// Notes:   offset saturates at the top of the range
`timescale 1ns/1ps
module ict_sfr_penalty
	import ict_pkg::*;
#(
	parameter int WAIT_W = 3
) (
	input  wire ict_pkg::ict_sfr_class_e sfrClass,
	input  wire logic                    isWrite,
	input  wire logic [2:0]              periphState,
	input  wire logic [WAIT_W-1:0]       waitCount,
	input  wire logic                    highSpeed,
	output logic [3:0]                   perAccess
);
	logic [3:0] lo;
	logic [3:0] span;

	always_comb begin
		lo   = 4'h0;
		span = 4'h0;
		unique case (sfrClass)
			ICT_SFR_TIMER_ZERO: begin
				lo   = isWrite ? 4'h0 : 4'h1;
				span = isWrite ? 4'h0 : 4'h1;
			end
			ICT_SFR_TIMER_ONE_TWO: begin
				lo   = isWrite ? 4'h0 : 4'h1;
				span = isWrite ? 4'h0 : 4'h3;
			end
			ICT_SFR_TIMER_THREE: begin
				lo   = isWrite ? 4'h0 : 4'h1;
				span = isWrite ? 4'h0 : 4'h7;
			end
			ICT_SFR_UPDOWN: begin
				lo   = isWrite ? 4'h0 : 4'h1;
				span = 4'h7;
			end
			ICT_SFR_COMPARE: begin
				lo   = isWrite ? 4'h0 : 4'h1;
				span = 4'h1;
			end
			ICT_SFR_UPDOWN_COMPARE: begin
				lo   = isWrite ? 4'h0 : 4'h1;
				span = 4'h5;
			end
			ICT_SFR_TIMER_MODE: span = isWrite ? 4'h1 : 4'h0;
			ICT_SFR_UPDOWN_MODE: span = isWrite ? 4'h3 : 4'h0;
			ICT_SFR_IRQ_CTRL: lo = isWrite ? 4'h1 : 4'h2;
			// waits only apply when not in high-speed fetch
			ICT_SFR_EXTERNAL: lo = highSpeed ? 4'h0 : 4'(waitCount);
			ICT_SFR_WAIT_CTRL: lo = isWrite ? 4'h1 : 4'h0;
			default: lo = 4'h0;
		endcase
		perAccess = lo + (({1'b0, periphState} > span) ? span : {1'b0, periphState});
	end
endmodule

// ### core/ict_cycle_timer.sv
// Purpose: per-instruction clock accounting for the 16-bit core
// Assumes: one instruction descriptor per instrValid pulse
// Notes:   result appears one clock after the descriptor
// What this block does
// - high-speed internal code: base is summed clocks
// - normal fetch: max of clocks, bytes times (3+n)
// - no high-speed selected means normal rule applies
// - low special window short access adds four
// - two-operand short access counts each window operand
// - register delay is per-access times access count
// - timer count reads add state-dependent ranged delay
// - compare registers add 1-2 read, 0-1 write
// - updown/timer3 compares add 1-6 read, 0-5 write
// - interrupt control registers add two read, one write
// - external register window adds n, or zero high-speed
// - branch flushes queue, adds 7-8 or 7-10+n
// - ports become inputs after reset
// - reset, break, trap vectors fixed, ignore table base
// - eight-bit bus: upper pins carry address only
// - wait count comes from wait control register
// - after reset all regions use normal fetch
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ict_cycle_timer
	import ict_pkg::*;
#(
	parameter int WAIT_W = 3
) (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    instrValid,
	input  wire logic [15:0]             codeAddr,
	input  wire logic [7:0]              instrClocks,
	input  wire logic [3:0]              instrBytes,
	input  wire logic                    saddrUseA,
	input  wire logic [15:0]             saddrAddrA,
	input  wire logic [1:0]              saddrAccA,
	input  wire logic                    saddrUseB,
	input  wire logic [15:0]             saddrAddrB,
	input  wire logic [1:0]              saddrAccB,
	input  wire ict_pkg::ict_sfr_class_e sfrClass,
	input  wire logic                    sfrWrite,
	input  wire logic [2:0]              sfrAccesses,
	input  wire logic [2:0]              periphState,
	input  wire logic                    isBranch,
	input  wire logic [1:0]              fetchPhase,
	input  wire logic                    vectorTableBaseFlag,
	input  wire logic                    busAddrPhase,
	input  wire logic [15:0]             busAddr,
	input  wire logic [15:0]             busData,
	output logic                         resultValid,
	output logic [11:0]                  cycleTotal,
	output logic [7:0]                   upperBus,
	output logic [7:0]                   portOut,
	output logic [7:0]                   portOe,
	output logic [15:0]                  resetVector,
	output logic [15:0]                  breakVector,
	output logic [15:0]                  trapVector
);
	// ------------------------------------------------------------
	// registers and APB slave
	// ------------------------------------------------------------
	logic [15:0] waitCtrl_reg, waitCtrl_next;
	logic [31:0] busCtrl_reg, busCtrl_next;
	logic [7:0]  portOut_reg, portOut_next;
	logic [31:0] cycAccum_reg, cycAccum_next;
	logic        apbWr;
	logic        mapped;

	assign apbWr   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign mapped  = paddr == OFS_WAIT_CTRL || paddr == OFS_BUS_CTRL || paddr == OFS_LAST_TOTAL ||
		paddr == OFS_CYC_ACCUM || paddr == OFS_PORT_OUT;
	// unmapped offsets answer with an error and read zero
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		unique case (paddr)
			OFS_WAIT_CTRL:  prdata = {16'h0000, waitCtrl_reg};
			OFS_BUS_CTRL:   prdata = busCtrl_reg;
			OFS_LAST_TOTAL: prdata = {20'h0_0000, cycleTotal};
			OFS_CYC_ACCUM:  prdata = cycAccum_reg;
			OFS_PORT_OUT:   prdata = {24'h00_0000, portOut_reg};
			default:        prdata = 32'h0000_0000;
		endcase
	end

	always_comb begin
		waitCtrl_next = waitCtrl_reg;
		busCtrl_next  = busCtrl_reg;
		portOut_next  = portOut_reg;
		if (apbWr && paddr == OFS_WAIT_CTRL) begin
			waitCtrl_next = pwdata[15:0];
		end
		if (apbWr && paddr == OFS_BUS_CTRL) begin
			busCtrl_next = pwdata;
		end
		if (apbWr && paddr == OFS_PORT_OUT) begin
			portOut_next = pwdata[7:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			waitCtrl_reg <= WAIT_CTRL_RST;
			busCtrl_reg  <= BUS_CTRL_RST;
			portOut_reg  <= 8'h00;
		end else begin
			waitCtrl_reg <= waitCtrl_next;
			busCtrl_reg  <= busCtrl_next;
			portOut_reg  <= portOut_next;
		end
	end

	// ------------------------------------------------------------
	// pins and vectors
	// ------------------------------------------------------------
	// latch value is don't-care while the driver is off
	assign portOut     = portOut_reg;
	assign portOe      = busCtrl_reg[PORT_DIR_LSB +: 8];
	assign upperBus    = (busCtrl_reg[BUS8_BIT] || busAddrPhase) ? busAddr[15:8] : busData[15:8];
	// table base only moves the other vectors
	assign resetVector = VEC_RESET;
	assign breakVector = VEC_BREAK;
	assign trapVector  = VEC_TRAP;

	// ------------------------------------------------------------
	// region decode and base count
	// ------------------------------------------------------------
	logic [3:0]        regionNib;
	logic [WAIT_W-1:0] waitN;
	logic              hsEff;
	logic              internalCode;
	logic [11:0]       clocksWide;
	logic [11:0]       fetchBound;
	logic [11:0]       baseNext;

	assign regionNib    = waitCtrl_reg[codeAddr[15:14]*REGION_NIB +: REGION_NIB];
	assign waitN        = regionNib[WAIT_LSB +: WAIT_W];
	assign internalCode = codeAddr <= ROM_LAST || (codeAddr >= PRAM_FIRST && codeAddr <= PRAM_LAST);
	// external code can never use high-speed fetch
	assign hsEff        = regionNib[HS_BIT] && internalCode;
	assign clocksWide   = {4'h0, instrClocks};
	assign fetchBound   = 12'(instrBytes * (FETCH_BASE + 4'(waitN)));

	always_comb begin
		if (hsEff) begin
			baseNext = clocksWide;
		end else begin
			baseNext = (fetchBound > clocksWide) ? fetchBound : clocksWide;
		end
	end

	// ------------------------------------------------------------
	// correction factors
	// ------------------------------------------------------------
	logic        inWinA, inWinB;
	logic [11:0] saddrNext;
	logic [3:0]  perAccess;
	logic [11:0] sfrNext;
	logic [11:0] flushNext;
	logic [1:0]  flushSpan;

	assign inWinA    = saddrUseA && saddrAddrA >= SFR_LO_FIRST && saddrAddrA <= SFR_LO_LAST;
	assign inWinB    = saddrUseB && saddrAddrB >= SFR_LO_FIRST && saddrAddrB <= SFR_LO_LAST;
	// each window operand counted on its own
	assign saddrNext = 12'((inWinA ? saddrAccA : 2'd0) * SADDR_PENALTY) +
		12'((inWinB ? saddrAccB : 2'd0) * SADDR_PENALTY);

	ict_sfr_penalty #(
		.WAIT_W (WAIT_W)
	) u_penalty (
		.sfrClass    (sfrClass),
		.isWrite     (sfrWrite),
		.periphState (periphState),
		.waitCount   (waitN),
		.highSpeed   (hsEff),
		.perAccess   (perAccess)
	);

	assign sfrNext   = 12'(perAccess * sfrAccesses);
	assign flushSpan = hsEff ? FLUSH_HS_SPAN : FLUSH_NF_SPAN;

	always_comb begin
		flushNext = 12'h000;
		if (isBranch) begin
			flushNext = 12'(FLUSH_BASE) + 12'((fetchPhase > flushSpan) ? flushSpan : fetchPhase);
			if (!hsEff) begin
				flushNext = flushNext + 12'(waitN);
			end
		end
	end

	// ------------------------------------------------------------
	// result registers
	// ------------------------------------------------------------
	logic        valid_reg, valid_next;
	logic [11:0] base_reg, base_next;
	logic [11:0] saddr_reg, saddr_next;
	logic [11:0] sfr_reg, sfr_next;
	logic [11:0] flush_reg, flush_next;
	logic [11:0] total_reg, total_next;

	always_comb begin
		valid_next    = instrValid;
		base_next     = base_reg;
		saddr_next    = saddr_reg;
		sfr_next      = sfr_reg;
		flush_next    = flush_reg;
		total_next    = total_reg;
		cycAccum_next = cycAccum_reg;
		if (instrValid) begin
			base_next     = baseNext;
			saddr_next    = saddrNext;
			sfr_next      = sfrNext;
			flush_next    = flushNext;
			total_next    = baseNext + saddrNext + sfrNext + flushNext;
			cycAccum_next = cycAccum_reg + 32'(total_next);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			valid_reg    <= 1'b0;
			base_reg     <= 12'h000;
			saddr_reg    <= 12'h000;
			sfr_reg      <= 12'h000;
			flush_reg    <= 12'h000;
			total_reg    <= 12'h000;
			cycAccum_reg <= 32'h0000_0000;
		end else begin
			valid_reg    <= valid_next;
			base_reg     <= base_next;
			saddr_reg    <= saddr_next;
			sfr_reg      <= sfr_next;
			flush_reg    <= flush_next;
			total_reg    <= total_next;
			cycAccum_reg <= cycAccum_next;
		end
	end

	assign resultValid = valid_reg;
	assign cycleTotal  = total_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence instrHs;
		instrValid && hsEff;
	endsequence
	sequence instrNf;
		instrValid && !hsEff;
	endsequence

	base_high_speed_a: assert property (@(posedge clock) disable iff (!rst_n)
		instrHs |=> base_reg == {4'h0, $past(instrClocks)})
		else $error("high-speed base is not the clock sum");
	base_normal_a: assert property (@(posedge clock) disable iff (!rst_n)
		instrNf |=> base_reg >= {4'h0, $past(instrClocks)} && base_reg >= $past(fetchBound) &&
			(base_reg == {4'h0, $past(instrClocks)} || base_reg == $past(fetchBound)))
		else $error("normal base is not the larger value");
	external_normal_a: assert property (@(posedge clock) disable iff (!rst_n)
		instrValid && !internalCode |-> !hsEff)
		else $error("external code took high-speed fetch");
	saddr_one_a: assert property (@(posedge clock) disable iff (!rst_n)
		instrValid && inWinA && !saddrUseB && saddrAccA == 2'd1 |=> saddr_reg == 12'd4)
		else $error("single window access not four clocks");
	saddr_two_a: assert property (@(posedge clock) disable iff (!rst_n)
		instrValid && inWinA && inWinB && saddrAccA == 2'd1 && saddrAccB == 2'd1 |=> saddr_reg == 12'd8)
		else $error("two window operands not counted twice");
	sfr_product_a: assert property (@(posedge clock) disable iff (!rst_n)
		instrValid |=> sfr_reg == 12'($past(perAccess) * $past(sfrAccesses)))
		else $error("register delay not per-access times count");
	timer_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		sfrClass == ICT_SFR_TIMER_THREE && !sfrWrite |-> perAccess >= 4'd1 && perAccess <= 4'd8)
		else $error("timer three read outside one to eight");
	cmp_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		sfrClass == ICT_SFR_COMPARE |-> perAccess <= (sfrWrite ? 4'd1 : 4'd2))
		else $error("compare register delay out of range");
	udcmp_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		sfrClass == ICT_SFR_UPDOWN_COMPARE && sfrWrite |-> perAccess <= 4'd5)
		else $error("updown compare write delay above five");
	irq_fixed_a: assert property (@(posedge clock) disable iff (!rst_n)
		sfrClass == ICT_SFR_IRQ_CTRL |-> perAccess == (sfrWrite ? 4'd1 : 4'd2))
		else $error("interrupt control delay not fixed");
	ext_window_a: assert property (@(posedge clock) disable iff (!rst_n)
		sfrClass == ICT_SFR_EXTERNAL && periphState == 3'd0 |-> perAccess == (hsEff ? 4'd0 : 4'(waitN)))
		else $error("external window delay wrong");
	flush_hs_a: assert property (@(posedge clock) disable iff (!rst_n)
		(instrHs and isBranch) |=> flush_reg >= 12'd7 && flush_reg <= 12'd8 ##1 1'b1)
		else $error("high-speed flush outside seven to eight");
	port_hiz_a: assert property (@(posedge clock)
		!$past(rst_n) |-> portOe == 8'h00)
		else $error("port driver on after reset");
	vector_fixed_a: assert property (@(posedge clock) disable iff (!rst_n)
		$changed(vectorTableBaseFlag) |-> breakVector == 16'h003E && trapVector == 16'h003C)
		else $error("fixed vector moved with table base");
	bus8_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
		busCtrl_reg[BUS8_BIT] |-> upperBus == busAddr[15:8])
		else $error("upper bus carried data on 8-bit bus");
	reset_normal_a: assert property (@(posedge clock)
		!$past(rst_n) |-> waitCtrl_reg == 16'h0000)
		else $error("region not normal fetch after reset");
	total_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
		instrValid ##1 resultValid |-> cycleTotal == base_reg + saddr_reg + sfr_reg + flush_reg)
		else $error("total does not combine the parts");
endmodule

// ### testbench/ict_ext_bus_model.sv
// Purpose: external bus device that answers on the multiplexed data lines
// Assumes: device drives data whenever the bus is not in its address phase
// Notes:   released lines show the inverse of the last value, never a stale copy
`timescale 1ns/1ps
module ict_ext_bus_model #(
	parameter logic [15:0] RESP_KEY = 16'h5A5A
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        busAddrPhase,
	input  wire logic [15:0] busAddr,
	output logic [15:0]      busData
);
	logic [15:0] lastData;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			lastData <= 16'h0000;
		else if (!busAddrPhase)
			lastData <= busAddr ^ RESP_KEY;
	end
	// address phase: device off the lines, so no stale data can pass for a match
	assign busData = busAddrPhase ? ~lastData : (busAddr ^ RESP_KEY);
endmodule

// ### testbench/ict_cycle_timer_tb.sv
// Purpose: self-checking bench for the instruction cycle timer
// Assumes: zero-wait APB slave, result one clock after the descriptor
// Notes:   descriptor defaults are deliberately nonzero to expose misuse
`timescale 1ns/1ps
module ict_cycle_timer_tb;
	import ict_pkg::*;
	logic clock = 0, rst_n = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = 0, upperBus, portOut, portOe;
	logic [31:0] pwdata = 0, prdata, rd;
	logic instrValid = 0, saddrUseA = 0, saddrUseB = 0, sfrWrite = 0, isBranch = 0;
	logic [15:0] codeAddr = 0, saddrAddrA = 0, saddrAddrB = 0, busAddr = 0, busData;
	logic [7:0] instrClocks = 0;
	logic [3:0] instrBytes = 0;
	logic [1:0] saddrAccA = 0, saddrAccB = 0, fetchPhase = 0;
	logic [2:0] sfrAccesses = 0, periphState = 0;
	ict_sfr_class_e sfrClass = ICT_SFR_PLAIN;
	logic vectorTableBaseFlag = 0, busAddrPhase = 0, resultValid;
	logic [11:0] cycleTotal;
	logic [15:0] resetVector, breakVector, trapVector;
	int error_cnt = 0, checks = 0, cycles = 0, accum = 0;
	int loRd[12] = '{0, 1, 1, 1, 1, 1, 1, 0, 0, 2, 0, 0};
	int spRd[12] = '{0, 1, 3, 7, 7, 1, 5, 0, 0, 0, 0, 0};
	int loWr[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 1};
	int spWr[12] = '{0, 0, 0, 0, 7, 1, 5, 1, 3, 0, 0, 0};

	always #5 clock = ~clock;

	ict_cycle_timer #(.WAIT_W(3)) dut_u (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instrValid(instrValid),
		.codeAddr(codeAddr), .instrClocks(instrClocks), .instrBytes(instrBytes), .saddrUseA(saddrUseA),
		.saddrAddrA(saddrAddrA), .saddrAccA(saddrAccA), .saddrUseB(saddrUseB), .saddrAddrB(saddrAddrB),
		.saddrAccB(saddrAccB), .sfrClass(sfrClass), .sfrWrite(sfrWrite), .sfrAccesses(sfrAccesses),
		.periphState(periphState), .isBranch(isBranch), .fetchPhase(fetchPhase),
		.vectorTableBaseFlag(vectorTableBaseFlag), .busAddrPhase(busAddrPhase), .busAddr(busAddr),
		.busData(busData), .resultValid(resultValid), .cycleTotal(cycleTotal), .upperBus(upperBus),
		.portOut(portOut), .portOe(portOe), .resetVector(resetVector), .breakVector(breakVector),
		.trapVector(trapVector)
	);
	ict_ext_bus_model bus_u (.clock(clock), .rst_n(rst_n), .busAddrPhase(busAddrPhase), .busAddr(busAddr),
		.busData(busData));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic results;
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic desc(input logic [15:0] code, input logic [7:0] clk, input logic [3:0] bytes);
		@(posedge clock);
		codeAddr    <= code;
		instrClocks <= clk;
		instrBytes  <= bytes;
		saddrUseA   <= 1'b0;
		saddrUseB   <= 1'b0;
		saddrAddrA  <= 16'hFF10;
		saddrAddrB  <= 16'hFF10;
		saddrAccA   <= 2'h3;
		saddrAccB   <= 2'h3;
		sfrClass    <= ICT_SFR_PLAIN;
		sfrWrite    <= 1'b0;
		sfrAccesses <= 3'h7;
		periphState <= 3'h7;
		isBranch    <= 1'b0;
		fetchPhase  <= 2'h3;
	endtask

	task automatic instr(input int exp);
		@(posedge clock);
		instrValid <= 1'b1;
		@(posedge clock);
		instrValid <= 1'b0;
		#1;
		chk({31'h0, resultValid}, 32'h1);
		chk({20'h0, cycleTotal}, exp);
		accum += exp;
	endtask

	task automatic fetch(input logic [15:0] code, input int exp);
		desc(code, 8'h05, 4'h3);
		instr(exp);
	endtask

	task automatic sad(input logic ua, input logic [15:0] aa, input logic [1:0] ca,
		input logic ub, input logic [15:0] ab, input logic [1:0] cb, input int exp);
		desc(16'h0100, 8'h0A, 4'h1);
		saddrUseA  <= ua;
		saddrAddrA <= aa;
		saddrAccA  <= ca;
		saddrUseB  <= ub;
		saddrAddrB <= ab;
		saddrAccB  <= cb;
		instr(exp);
	endtask

	// expected per-access increase; external window follows fetch mode
	function automatic int pen(input int c, input int w, input int ps, input int n, input int hs);
		int sp;
		if (c == 10)
			return hs ? 0 : n;
		sp = w ? spWr[c] : spRd[c];
		return (w ? loWr[c] : loRd[c]) + (ps < sp ? ps : sp);
	endfunction

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			results();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		// falling edge at time zero so every register is reset before the first clock
		rst_n <= 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, OFS_WAIT_CTRL, 32'h0);
		chk(rd, {16'h0, WAIT_CTRL_RST});
		apb(1'b0, OFS_BUS_CTRL, 32'h0);
		chk(rd, BUS_CTRL_RST);
		chk({24'h0, portOe}, 32'h0);
		vectorTableBaseFlag <= 1'b1;
		@(posedge clock);
		#1;
		chk({resetVector, breakVector}, 32'h0000_003E);
		chk({16'h0, trapVector}, 32'h0000_003C);
		fetch(16'h0100, 9);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		apb(1'b0, 8'h14, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		// regions: r0 high-speed n0, r1 normal n2, r2 normal n0, r3 high-speed n1
		apb(1'b1, OFS_WAIT_CTRL, 32'h0000_9028);
		fetch(16'h0100, 5);
		fetch(16'h4000, 15);
		fetch(16'h8000, 9);
		fetch(16'hC000, 12);
		fetch(16'hF700, 5);
		fetch(16'hFDFF, 5);
		sad(1'b1, 16'hFF00, 2'h1, 1'b0, 16'hFF00, 2'h1, 14);
		sad(1'b1, 16'hFF1F, 2'h2, 1'b1, 16'hFF20, 2'h1, 18);
		sad(1'b1, 16'hFEFE, 2'h1, 1'b1, 16'hFF00, 2'h1, 14);
		sad(1'b1, 16'hFF00, 2'h1, 1'b1, 16'hFF1F, 2'h1, 18);
		sad(1'b0, 16'hFF10, 2'h3, 1'b0, 16'hFF10, 2'h3, 10);
		for (int c = 0; c < 12; c++)
			for (int w = 0; w < 2; w++)
				for (int ps = 0; ps < 8; ps++) begin
					desc(16'h0100, 8'h0A, 4'h1);
					sfrClass    <= ict_sfr_class_e'(c[3:0]);
					sfrWrite    <= w[0];
					periphState <= ps[2:0];
					sfrAccesses <= 3'h3;
					instr(10 + 3 * pen(c, w, ps, 0, 1));
				end
		desc(16'h4000, 8'h28, 4'h1);
		sfrClass    <= ICT_SFR_EXTERNAL;
		sfrAccesses <= 3'h3;
		instr(40 + 3 * pen(10, 0, 0, 2, 0));
		for (int fp = 0; fp < 4; fp++) begin
			desc(16'h0100, 8'h0A, 4'h1);
			isBranch   <= 1'b1;
			fetchPhase <= fp[1:0];
			instr(17 + (fp > 1 ? 1 : fp));
			desc(16'h4000, 8'h28, 4'h1);
			isBranch   <= 1'b1;
			fetchPhase <= fp[1:0];
			instr(49 + fp);
		end
		desc(16'h4000, 8'h05, 4'h3);
		saddrUseA   <= 1'b1;
		saddrAddrA  <= 16'hFF00;
		saddrAccA   <= 2'h1;
		sfrClass    <= ICT_SFR_IRQ_CTRL;
		sfrAccesses <= 3'h2;
		isBranch    <= 1'b1;
		instr(35);
		apb(1'b1, OFS_LAST_TOTAL, 32'h0);
		apb(1'b0, OFS_LAST_TOTAL, 32'h0);
		chk(rd, 32'd35);
		apb(1'b0, OFS_CYC_ACCUM, 32'h0);
		chk(rd, accum);
		apb(1'b1, OFS_BUS_CTRL, 32'h0000_FF01);
		busAddr      <= 16'hA5C2;
		busAddrPhase <= 1'b0;
		@(posedge clock);
		#1;
		chk({upperBus, portOe}, 32'h0000_A5FF);
		apb(1'b1, OFS_BUS_CTRL, 32'h0000_0F00);
		#1;
		chk({upperBus, portOe}, 32'h0000_FF0F);
		@(posedge clock);
		busAddrPhase <= 1'b1;
		@(posedge clock);
		#1;
		chk({24'h0, upperBus}, 32'h0000_00A5);
		apb(1'b1, OFS_PORT_OUT, 32'h0000_003C);
		apb(1'b0, OFS_PORT_OUT, 32'h0);
		chk({rd[23:0], portOut}, 32'h0000_3C3C);
		// second reset in mid-run must drop drivers and fetch modes again
		rst_n <= 1'b0;
		@(posedge clock);
		#1;
		chk({23'h0, resultValid, portOe}, 32'h0);
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, OFS_WAIT_CTRL, 32'h0);
		chk(rd, 32'h0);
		results();
	end
endmodule
